// ==== shared/brake_pkg.sv ====
`default_nettype none
package brake_pkg;
  // timing: one tick is one microsecond of the 125 MHz clock
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

  // register word indices (byte address = index * 4)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_DC_CURRENT = 4'h1;
  localparam logic [3:0] IDX_DC_TIME = 4'h2;
  localparam logic [3:0] IDX_DEMAG_TIME = 4'h3;
  localparam logic [3:0] IDX_START_FREQ = 4'h4;
  localparam logic [3:0] IDX_NORMAL_RAMP = 4'h5;
  localparam logic [3:0] IDX_QUICK_RAMP = 4'h6;
  localparam logic [3:0] IDX_COMPOUND_CURRENT = 4'h7;
  localparam logic [3:0] IDX_SUPPLY_VOLTAGE = 4'h8;
  localparam logic [3:0] IDX_OV_LIMIT = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'hA;
  localparam logic [3:0] IDX_THRESHOLD = 4'hB;
  localparam logic [3:0] IDX_OUT_FREQ = 4'hC;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'hD;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'hE;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'hF;
  localparam int unsigned NUM_CFG = 10;

  // reset values of the writable configuration words
  localparam logic [31:0] CFG_RESET [NUM_CFG] = '{
    32'h0000_0003, 32'h0000_0100, 32'h0000_03E8, 32'h0000_0064, 32'h0000_01F4,
    32'h0000_000A, 32'h0000_0005, 32'h0000_0080, 32'h0000_0190, 32'h0000_0320};

  // control word fields
  localparam int unsigned CTRL_POST_STOP_BIT = 0;
  localparam int unsigned CTRL_COMPOUND_BIT = 1;
  localparam int unsigned CTRL_AUTO_DETECT_BIT = 2;
  localparam int unsigned CTRL_FLYING_BIT = 3;
  localparam int unsigned CTRL_MODE_LSB = 4;
  localparam logic [1:0] MODE_VF = 2'h0;
  localparam logic [1:0] MODE_SENSORLESS_VECTOR_CONTROL = 2'h1;
  localparam logic [1:0] MODE_VC = 2'h2;

  // 1.13 * sqrt(2) = 1.598, as 1637 / 1024
  localparam logic [11:0] THR_MUL = 12'h665;
  localparam int unsigned THR_SHIFT = 10;
  // speed mismatch allowed on resume, in frequency units
  localparam logic [15:0] SPEED_TOL = 16'h0004;

  // interrupt bits
  localparam int unsigned IRQ_BRAKE_START = 0;
  localparam int unsigned IRQ_BRAKE_END = 1;
  localparam int unsigned IRQ_OVERVOLT = 2;
  localparam int unsigned IRQ_OVERCURR = 3;
  localparam int unsigned IRQ_W = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_RAMP = 6'h02,
    ST_DEMAG = 6'h04,
    ST_INJECT = 6'h08,
    ST_BLOCKED = 6'h10,
    ST_RESUME = 6'h20
  } brake_state_t;

  typedef struct packed {
    logic post_stop_en;
    logic compound_en;
    logic auto_detect;
    logic flying_en;
    logic [1:0] mode;
    logic [15:0] dc_current;
    logic [19:0] dc_time;
    logic [19:0] demag_time;
    logic [15:0] start_freq;
    logic [15:0] normal_ramp;
    logic [15:0] quick_ramp;
    logic [15:0] compound_current;
    logic [15:0] supply_voltage;
    logic [15:0] ov_limit;
  } brake_cfg_t;
endpackage
`default_nettype wire

// ==== rtl/dc_and_compound_brake_sequencer.sv ====
// Contract
// (RULE_01) stop with post-stop brake ramps to start frequency
// (RULE_02) pulses blocked for the demagnetizing time first
// (RULE_03) inject current for brake time, flag bit 0
// (RULE_04) pulses blocked once the brake time ends
// (RULE_05) direct select brakes without ramp
// (RULE_06) withdrawn select accelerates back to setpoint
// (RULE_07) speed mismatch on resume raises overcurrent
// (RULE_08) too steep stop ramp trips on overvoltage
// (RULE_09) external speed input ignored while braking
// (RULE_10) injected current holds the motor at standstill
// (RULE_11) compound current added above link threshold
// (RULE_12) threshold is 1.13 root two supply voltage
// (RULE_13) auto mode takes measured switch-on level at run-up
// (RULE_14) threshold follows a new supply setting immediately
// (RULE_15) compound only under open-loop voltage-frequency control
// (RULE_16) compound suppressed by flying restart, dc brake, vector
// (RULE_17) normal stop uses normal ramp, quick uses quick
// (RULE_18) flag cleared at time end or select withdrawal
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module dc_and_compound_brake_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // commands
  input wire logic normal_stop_command,
  input wire logic quick_stop_command,
  input wire logic dc_brake_direct_select,
  input wire logic [15:0] speed_setpoint,
  // drive feedback
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] dc_link_voltage,
  input wire logic [15:0] dc_link_switch_on_level,
  input wire logic line_connected,
  input wire logic flying_restart_active,
  // inverter stage
  output logic pulse_enable,
  output logic [15:0] dc_current_cmd,
  output logic [15:0] output_freq,
  output logic dc_brake_active,
  // interrupt
  output logic irq
);
  import brake_pkg::*;

  logic [31:0] cfg_q [NUM_CFG];
  brake_cfg_t cfg;
  brake_state_t state_q, state_d;
  logic [6:0] tick_q;
  logic tick;
  logic [19:0] tcnt_q;
  logic [15:0] rcnt_q;
  logic [15:0] freq_q, freq_d;
  logic [15:0] setpoint_q;
  logic quick_q;
  logic via_direct_q;
  logic line_q;
  logic [15:0] switch_on_q;
  logic [15:0] thr_q;
  logic [IRQ_W-1:0] irq_status_q, irq_enable_q, irq_event, irq_clear;
  logic aw_held_q, w_held_q;
  logic [3:0] aw_idx_q;
  logic aw_ok_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // byte-lane merge, used by every configuration word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // configuration fields
  assign cfg.post_stop_en = cfg_q[IDX_CTRL][CTRL_POST_STOP_BIT];
  assign cfg.compound_en = cfg_q[IDX_CTRL][CTRL_COMPOUND_BIT];
  assign cfg.auto_detect = cfg_q[IDX_CTRL][CTRL_AUTO_DETECT_BIT];
  assign cfg.flying_en = cfg_q[IDX_CTRL][CTRL_FLYING_BIT];
  assign cfg.mode = cfg_q[IDX_CTRL][CTRL_MODE_LSB +: 2];
  assign cfg.dc_current = cfg_q[IDX_DC_CURRENT][15:0];
  assign cfg.dc_time = cfg_q[IDX_DC_TIME][19:0];
  assign cfg.demag_time = cfg_q[IDX_DEMAG_TIME][19:0];
  assign cfg.start_freq = cfg_q[IDX_START_FREQ][15:0];
  assign cfg.normal_ramp = cfg_q[IDX_NORMAL_RAMP][15:0];
  assign cfg.quick_ramp = cfg_q[IDX_QUICK_RAMP][15:0];
  assign cfg.compound_current = cfg_q[IDX_COMPOUND_CURRENT][15:0];
  assign cfg.supply_voltage = cfg_q[IDX_SUPPLY_VOLTAGE][15:0];
  assign cfg.ov_limit = cfg_q[IDX_OV_LIMIT][15:0];

  // write path: address and data may arrive in either order
  wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  // out-of-map writes answer slverr and touch nothing
  wire wr_ok = wr_fire && aw_ok_q;
  wire wr_mapped = (aw_idx_q != IDX_STATUS) && (aw_idx_q != IDX_THRESHOLD) &&
                   (aw_idx_q != IDX_OUT_FREQ) && (aw_idx_q != IDX_IRQ_STATUS);
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign irq_clear = (wr_ok && aw_idx_q == IDX_IRQ_CLEAR) ? w_data_q[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 4'h0;
      aw_ok_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[5:2];
        // the master may move awaddr once taken, so keep the range check too
        aw_ok_q <= (s_axi_awaddr[7:6] == 2'h0);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_mapped && aw_ok_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration words, one generate copy per word
  for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_q[i] <= CFG_RESET[i];
      end else if (wr_ok && aw_idx_q == 4'(i)) begin
        cfg_q[i] <= merge(cfg_q[i], w_data_q, w_strb_q);
      end
    end
  end

  // read path; upper address bits beyond the map answer slverr
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr[5:2])
      IDX_STATUS: rd_word = {26'h0, state_q == ST_RESUME, state_q == ST_BLOCKED,
                             state_q == ST_DEMAG, state_q == ST_RAMP, 1'b0, dc_brake_active};
      IDX_THRESHOLD: rd_word = {16'h0, thr_q};
      IDX_OUT_FREQ: rd_word = {16'h0, freq_q};
      IDX_IRQ_STATUS: rd_word = {28'h0, irq_status_q};
      IDX_IRQ_CLEAR: rd_word = 32'h0000_0000;
      IDX_IRQ_ENABLE: rd_word = {28'h0, irq_enable_q};
      default: rd_word = cfg_q[s_axi_araddr[5:2]];
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= (s_axi_araddr[7:6] == 2'h0) ? rd_word : 32'h0000_0000;
      s_axi_rresp <= (s_axi_araddr[7:6] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // microsecond tick shared by the brake timer and the ramp
  assign tick = (tick_q == TICK_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 7'h00;
    end else begin
      tick_q <= tick ? 7'h00 : tick_q + 7'h01;
    end
  end

  // sequence decisions
  wire stop_cmd = normal_stop_command || quick_stop_command;
  wire state_change = (state_d != state_q);
  // (RULE_17) ramp time choice
  wire [15:0] ramp_len = quick_q ? cfg.quick_ramp : cfg.normal_ramp;
  wire ramp_hit = tick && (rcnt_q >= ramp_len);
  wire demag_done = (tcnt_q >= cfg.demag_time);
  wire inject_done = (tcnt_q >= cfg.dc_time);
  wire ov_trip = (dc_link_voltage > cfg.ov_limit);
  wire braking = (state_q == ST_DEMAG) || (state_q == ST_INJECT) || (state_q == ST_BLOCKED);
  wire resume_entry = (state_d == ST_RESUME) && (state_q != ST_RESUME);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        // (RULE_05) direct entry without ramp
        if (dc_brake_direct_select) begin
          state_d = ST_DEMAG;
        end else if (stop_cmd) begin
          state_d = ST_RAMP;
        end
      end
      ST_RAMP: begin
        // (RULE_08) overvoltage trip on ramp
        if (dc_brake_direct_select) begin
          state_d = ST_DEMAG;
        end else if (ov_trip) begin
          state_d = ST_BLOCKED;
        end else if (cfg.post_stop_en && freq_q <= cfg.start_freq) begin
          // (RULE_01) start frequency reached
          state_d = ST_DEMAG;
        end else if (!cfg.post_stop_en && freq_q == 16'h0000) begin
          state_d = ST_BLOCKED;
        end else if (!stop_cmd) begin
          state_d = ST_RESUME;
        end
      end
      ST_DEMAG: begin
        // (RULE_02) pause before current
        if (via_direct_q && !dc_brake_direct_select) begin
          state_d = ST_RESUME;
        end else if (demag_done) begin
          state_d = ST_INJECT;
        end
      end
      ST_INJECT: begin
        // (RULE_18) withdrawal or time end
        if (via_direct_q && !dc_brake_direct_select) begin
          state_d = ST_RESUME;
        end else if (inject_done) begin
          // (RULE_04) block after brake time
          state_d = ST_BLOCKED;
        end
      end
      ST_BLOCKED: begin
        if (via_direct_q ? !dc_brake_direct_select : !stop_cmd) begin
          state_d = ST_RESUME;
        end
      end
      ST_RESUME: begin
        // (RULE_06) back to setpoint
        if (dc_brake_direct_select) begin
          state_d = ST_DEMAG;
        end else if (stop_cmd) begin
          state_d = ST_RAMP;
        end else if (freq_q == setpoint_q) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  // output frequency
  always_comb begin
    freq_d = freq_q;
    case (state_q)
      ST_RUN: freq_d = setpoint_q;
      ST_RAMP: freq_d = (ramp_hit && freq_q != 16'h0000) ? freq_q - 16'h0001 : freq_q;
      ST_RESUME: begin
        if (ramp_hit && freq_q < setpoint_q) begin
          freq_d = freq_q + 16'h0001;
        end else if (ramp_hit && freq_q > setpoint_q) begin
          freq_d = freq_q - 16'h0001;
        end
      end
      default: freq_d = 16'h0000;
    endcase
    // (RULE_07) flying restart catches the spinning motor
    if (resume_entry && cfg.flying_en) begin
      freq_d = motor_speed;
    end else if (resume_entry && braking) begin
      freq_d = 16'h0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
      tcnt_q <= 20'h00000;
      rcnt_q <= 16'h0000;
      freq_q <= 16'h0000;
      quick_q <= 1'b0;
      via_direct_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tcnt_q <= state_change ? 20'h00000 : (tick ? tcnt_q + 20'h00001 : tcnt_q);
      rcnt_q <= (state_change || ramp_hit) ? 16'h0000 : (tick ? rcnt_q + 16'h0001 : rcnt_q);
      freq_q <= freq_d;
      if (state_d == ST_RAMP && state_q != ST_RAMP) begin
        quick_q <= quick_stop_command;
      end else if (state_d == ST_RESUME) begin
        quick_q <= 1'b0;
      end
      if (state_d == ST_DEMAG && state_q != ST_DEMAG) begin
        via_direct_q <= dc_brake_direct_select;
      end
    end
  end

  // (RULE_09) setpoint frozen while braking; the external input cannot steer the drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setpoint_q <= 16'h0000;
    end else if (!braking && state_d != ST_DEMAG) begin
      setpoint_q <= speed_setpoint;
    end
  end

  // compound threshold; the product is cut to the top of its useful range
  wire [27:0] thr_product = cfg.supply_voltage * THR_MUL;
  // (RULE_12) fixed formula
  wire [15:0] thr_formula = thr_product[THR_SHIFT +: 16];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q <= 1'b0;
      switch_on_q <= 16'h0000;
      thr_q <= 16'hFFFF; // out of reach until computed, so no compound blip after reset
    end else begin
      line_q <= line_connected;
      // (RULE_13) capture at run-up
      if (line_connected && !line_q) begin
        switch_on_q <= dc_link_switch_on_level;
      end
      // (RULE_14) recomputed every cycle, so a new supply value acts at once
      thr_q <= cfg.auto_detect ? switch_on_q : thr_formula;
    end
  end

  // (RULE_15) (RULE_16) compound permission
  wire compound_ok = cfg.compound_en && cfg.mode == MODE_VF && !flying_restart_active &&
                     (state_q == ST_RUN || state_q == ST_RAMP || state_q == ST_RESUME);
  // (RULE_11) compound current above threshold
  wire compound_on = compound_ok && (dc_link_voltage > thr_q);

  // inverter outputs registered from the next state so they line up with state_q
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_enable <= 1'b1;
      dc_current_cmd <= 16'h0000;
      output_freq <= 16'h0000;
      dc_brake_active <= 1'b0;
    end else begin
      pulse_enable <= (state_d != ST_DEMAG) && (state_d != ST_BLOCKED);
      // (RULE_03) (RULE_10) full current at zero frequency holds the shaft
      dc_current_cmd <= (state_d == ST_INJECT) ? cfg.dc_current : 16'h0000;
      if (state_d != ST_INJECT && compound_on && state_d == state_q) begin
        dc_current_cmd <= cfg.compound_current;
      end
      output_freq <= freq_d;
      dc_brake_active <= (state_d == ST_INJECT);
    end
  end

  // sticky events; a set in the clearing cycle wins
  assign irq_event[IRQ_BRAKE_START] = (state_d == ST_INJECT) && (state_q != ST_INJECT);
  assign irq_event[IRQ_BRAKE_END] = (state_q == ST_INJECT) && (state_d != ST_INJECT);
  assign irq_event[IRQ_OVERVOLT] = (state_q == ST_RAMP) && (state_d == ST_BLOCKED) && ov_trip;
  // (RULE_07) mismatch flagged as overcurrent
  assign irq_event[IRQ_OVERCURR] = resume_entry && braking && !cfg.flying_en &&
                                   (absdiff(motor_speed, 16'h0000) > SPEED_TOL);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= '0;
      irq_enable_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
      if (wr_ok && aw_idx_q == IDX_IRQ_ENABLE) begin
        irq_enable_q <= w_data_q[IRQ_W-1:0];
      end
      irq <= |(((irq_status_q & ~irq_clear) | irq_event) & irq_enable_q);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // (RULE_02) no switching in the pause
  demag_pulse_block_a: assert property (state_q == ST_DEMAG |-> !pulse_enable) // (RULE_02)
    else $error("pulses enabled during demagnetizing pause");
  // (RULE_03) flag and current with injection
  inject_flag_current_a: assert property (state_q == ST_INJECT |-> // (RULE_03)
    dc_brake_active && dc_current_cmd == $past(cfg.dc_current))
    else $error("injection without flag or current");
  // (RULE_04) blocked after brake time
  after_inject_block_a: assert property ( // (RULE_04)
    state_q == ST_INJECT && !via_direct_q && inject_done |=> !pulse_enable && !dc_brake_active)
    else $error("pulses not blocked after brake time");
  // (RULE_05) direct select skips the ramp
  direct_no_ramp_a: assert property ( // (RULE_05)
    state_q == ST_RUN && dc_brake_direct_select |=> state_q == ST_DEMAG && !pulse_enable)
    else $error("direct select did not start the pause");
  // (RULE_08) overvoltage trip
  ramp_ov_trip_a: assert property ( // (RULE_08)
    state_q == ST_RAMP && !dc_brake_direct_select && ov_trip
    |=> state_q == ST_BLOCKED && irq_status_q[IRQ_OVERVOLT])
    else $error("overvoltage on ramp did not trip");
  // (RULE_09) setpoint frozen
  setpoint_freeze_a: assert property ( // (RULE_09)
    braking && state_q == $past(state_q) |-> $stable(setpoint_q))
    else $error("setpoint moved during braking");
  // (RULE_12) threshold formula
  threshold_formula_a: assert property ( // (RULE_12)
    !cfg.auto_detect |=> thr_q == $past(thr_formula))
    else $error("compound threshold does not follow supply setting");
  // (RULE_16) suppression of compound current
  compound_gate_a: assert property ( // (RULE_16)
    state_q != ST_INJECT && dc_current_cmd != 16'h0000
    |-> $past(cfg.mode) == MODE_VF && !$past(flying_restart_active))
    else $error("compound current outside permitted mode");
  // (RULE_18) flag drops on withdrawal
  flag_withdraw_a: assert property ( // (RULE_18)
    state_q == ST_INJECT && via_direct_q && !dc_brake_direct_select
    |=> !dc_brake_active && dc_current_cmd == 16'h0000)
    else $error("flag kept after withdrawal");
  irq_level_a: assert property (##1 irq == |($past(irq_status_q & ~irq_clear | irq_event) &
                                             $past(irq_enable_q)))
    else $error("interrupt level wrong");
endmodule // dc_and_compound_brake_sequencer
`default_nettype wire

// ==== verif/motor_load_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module motor_load_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // inverter side
  input wire logic pulse_enable,
  input wire logic [15:0] dc_current_cmd,
  input wire logic [15:0] output_freq,
  input wire logic regen_high,
  // feedback
  output logic [15:0] motor_speed,
  output logic [15:0] dc_link_voltage
);
  logic [3:0] div_q;
  // link only rises when the bench makes the load regenerate
  assign dc_link_voltage = regen_high ? 16'h0384 : 16'h021C;
  // slow mechanics: dc current brakes, else speed trails the drive while pulses are enabled and holds while they are blocked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 4'h0;
      motor_speed <= 16'h0000;
    end else begin
      div_q <= div_q + 4'h1;
      if (div_q == 4'h0 && dc_current_cmd != 16'h0000 && motor_speed != 16'h0000) begin
        motor_speed <= motor_speed - 16'h0001;
      end else if (div_q == 4'h0 && pulse_enable) begin
        motor_speed <= output_freq;
      end
    end
  end
endmodule // motor_load_model
`default_nettype wire

// ==== verif/dc_and_compound_brake_sequencer_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module dc_and_compound_brake_sequencer_test;
  import brake_pkg::*;
  // bus and control inputs start idle
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic normal_stop_command = 1'b0, quick_stop_command = 1'b0, dc_brake_direct_select = 1'b0;
  logic line_connected = 1'b0, flying_restart_active = 1'b0, regen_high = 1'b0;
  logic [15:0] speed_setpoint = 16'h0028, dc_link_switch_on_level = 16'h0000;
  logic [15:0] motor_speed, dc_link_voltage, dc_current_cmd, output_freq;
  logic pulse_enable, dc_brake_active, irq;
  int miscompares = 0, total_checks = 0, n, m;
  localparam logic [5:0] CMP_CTRL [5] = '{6'h03, 6'h13, 6'h23, 6'h01, 6'h03};
  dc_and_compound_brake_sequencer i_dc_and_compound_brake_sequencer (.*);
  motor_load_model i_motor_load_model (.*);
  // 125 MHz
  always #4 aclk = ~aclk;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // address and data go out together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // no cycle limit: only the watchdog ends a stuck wait
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    chk("bresp", er, s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // the full sequence takes about 50000 cycles
  initial begin
    #(100000 * 8);
    miscompares++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < NUM_CFG; i++) begin
      rd(8'(4 * i), RESP_OKAY, d);
      chk("cfg_reset", CFG_RESET[i], d);
    end
    rd(8'h2C, RESP_OKAY, d);
    chk("threshold", (32'd400 * THR_MUL) >> THR_SHIFT, d);
    wr(8'h20, 32'h1F4, RESP_OKAY);
    rd(8'h2C, RESP_OKAY, d);
    chk("threshold_new", (32'd500 * THR_MUL) >> THR_SHIFT, d);
    wr(8'h40, 32'h0, RESP_SLVERR);
    rd(8'h40, RESP_SLVERR, d);
    chk("unmapped", 32'h0, d);
    // short times keep each brake to a few microseconds
    wr(8'h0C, 32'h2, RESP_OKAY);
    wr(8'h08, 32'h3, RESP_OKAY);
    wr(8'h10, 32'h14, RESP_OKAY);
    wr(8'h14, 32'h1, RESP_OKAY);
    wr(8'h18, 32'h0, RESP_OKAY);
    wr(8'h3C, 32'hF, RESP_OKAY);
    // direct brake while running at the setpoint, then run up to it again
    dc_brake_direct_select <= 1'b1;
    for (n = 0; n < 2000 && !dc_brake_active; n++) @(posedge aclk);
    chk("direct_inject", 1, dc_brake_active);
    dc_brake_direct_select <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("flag_withdrawn", 0, dc_brake_active);
    for (n = 0; n < 20000 && output_freq != 16'h0028; n++) @(posedge aclk);
    chk("resume_freq", 16'h0028, output_freq);
    // post-stop brake: ramp, pause, inject, block
    normal_stop_command <= 1'b1;
    for (n = 0; n < 20000 && pulse_enable; n++) @(posedge aclk);
    chk("ramp_end", 1, output_freq <= 16'h0014);
    chk("normal_ramp", 1, n > 4250 && n < 5750);
    for (m = 0; m < 2000 && !dc_brake_active; m++) @(posedge aclk);
    chk("demag", 1, m > 100 && m < 400);
    chk("inject_current", 16'h0100, dc_current_cmd);
    rd(8'h28, RESP_OKAY, d);
    chk("status_flag", 1, d[0]);
    speed_setpoint <= 16'h003C;
    for (m = 0; m < 2000 && dc_brake_active; m++) @(posedge aclk);
    chk("inject_time", 1, m > 240 && m < 510);
    chk("blocked", 0, pulse_enable);
    chk("speed_ignored", 0, output_freq);
    rd(8'h34, RESP_OKAY, d);
    chk("irq_events", 32'h3, d[1:0]);
    speed_setpoint <= 16'h0028;
    normal_stop_command <= 1'b0;
    for (n = 0; n < 20000 && output_freq != 16'h0028; n++) @(posedge aclk);
    quick_stop_command <= 1'b1;
    for (n = 0; n < 20000 && pulse_enable; n++) @(posedge aclk);
    chk("quick_ramp", 1, n > 2000 && n < 3000);
    for (m = 0; m < 2000 && !dc_brake_active; m++) @(posedge aclk);
    for (m = 0; m < 2000 && dc_brake_active; m++) @(posedge aclk);
    quick_stop_command <= 1'b0;
    for (n = 0; n < 20000 && output_freq != 16'h0028; n++) @(posedge aclk);
    // withdraw direct brake early, motor still turning
    wr(8'h38, 32'hF, RESP_OKAY);
    dc_brake_direct_select <= 1'b1;
    for (n = 0; n < 2000 && !dc_brake_active; n++) @(posedge aclk);
    repeat (40) @(posedge aclk);
    dc_brake_direct_select <= 1'b0;
    for (n = 0; n < 20000 && output_freq != 16'h0028; n++) @(posedge aclk);
    rd(8'h34, RESP_OKAY, d);
    chk("overcurrent", 1, d[3]);
    chk("irq_line", 1, irq);
    wr(8'h3C, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq_masked", 0, irq);
    wr(8'h38, 32'hF, RESP_OKAY);
    rd(8'h34, RESP_OKAY, d);
    chk("irq_cleared", 0, d);
    // compound only for v/f without flying restart, link above threshold
    regen_high <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {26'h0, CMP_CTRL[i]}, RESP_OKAY);
      flying_restart_active <= (i == 0);
      repeat (4) @(posedge aclk);
      chk("compound", (i == 4) ? 16'h0080 : 16'h0000, dc_current_cmd);
    end
    // link above the overvoltage limit while ramping down
    normal_stop_command <= 1'b1;
    repeat (300) @(posedge aclk);
    chk("ov_block", 0, pulse_enable);
    rd(8'h34, RESP_OKAY, d);
    chk("ov_event", 1, d[2]);
    wr(8'h00, 32'h7, RESP_OKAY);
    dc_link_switch_on_level <= 16'h02A0;
    line_connected <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h2C, RESP_OKAY, d);
    chk("auto_threshold", 32'h2A0, d);
    conclude;
  end
endmodule // dc_and_compound_brake_sequencer_test
`default_nettype wire
